// ---- iec_cpu_model.sv ----
// CPU core model that acknowledges pending requests
`timescale 1ns/1ps
module iec_cpu_model #(
  parameter int ACK_DLY = 2                  // Cycles before acknowledge
) (
  input  wire logic                  clk,     // Clock
  input  wire logic                  rst_b,   // Reset, low
  input  wire logic                  ack_en,  // Allow acknowledges
  input  wire iec_pkg::iec_cpu_req_t req,     // Request from controller
  output logic                       int_ack, // Acknowledge pulse
  output logic [4:0]                 ack_src  // Acknowledged source
);
  import iec_pkg::*;
  int cnt;                                    // Wait counter
  // Acknowledge only a pending request; source loaded with pulse, inverted every cycle between pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_ack <= 1'b0;
      ack_src <= 5'h00;
      cnt     <= 0;
    end else begin
      int_ack <= 1'b0;
      ack_src <= ~ack_src;
      if (int_ack || !(ack_en && req.req)) begin
        cnt <= 0;
      end else if (cnt == ACK_DLY) begin
        int_ack <= 1'b1;
        ack_src <= req.src;
        cnt     <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ---- iec_ctrl.sv ----
// Interrupt enable, priority and external flag controller
//
// Notes on behaviour
// R1: first enable: global, group 0-7, serial1, pins
// R2: second enable: pin12, serial0 events, pin8
// R3: third enable: timer4, timer matches, T0 overflow
// R4: fourth enable: interval, watchdog, watch, spi2, adc
// R5: pin 0-7 flags set on edge, software clears
// R6: high polarity holds edge codes pins 7-4
// R7: low polarity holds edge codes pins 3-0
// R8: upper polarity holds codes pins 12,11,10,8
// R9: pin 12,11,10,8 flags clear by zero or ack
// R10: timer0 match flag clears by zero or ack
// R11: timer3 flag clears by zero or ack
// R12: group level is high bit over low bit
// R13: service needs global and own enable set
// R14: six groups of four, lower number wins ties
`timescale 1ns/1ps
`include "iec_params.svh"
module iec_ctrl (
  input  wire logic                 clk,       // System clock
  input  wire logic                 rst_b,     // Async reset, low
  input  wire iec_pkg::iec_av_req_t avs_req,   // Avalon request
  output logic                      avs_waitrequest, // Avalon stall
  output logic [31:0]               avs_readdata,    // Avalon read data
  input  wire iec_pkg::iec_events_t evt,       // Pins and timer events
  input  wire logic [23:0]          periph_req,  // Other source levels
  input  wire logic                 int_ack,   // CPU acknowledge pulse
  input  wire logic [4:0]           ack_src,   // Acknowledged source
  output iec_pkg::iec_cpu_req_t     cpu_req,   // Request to CPU
  output logic                      irq        // Summary interrupt
);
  import iec_pkg::*;

  // ========================================
  // State
  typedef struct packed {
    logic        wait_n;
    logic [31:0] rdata;
    logic [7:0]  ie0;
    logic [7:0]  ie1;
    logic [7:0]  ie2;
    logic [7:0]  ie3;
    logic [7:0]  prio_low;
    logic [7:0]  prio_high;
    logic [7:0]  pol_low;
    logic [7:0]  pol_high;
    logic [7:0]  pol_upper;
    logic [7:0]  flags0;
    logic [7:0]  flags1;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [7:0]  pin_low_prev;
    logic [3:0]  pin_up_prev;
    iec_cpu_req_t cpu;
    logic        irq;
  } iec_state_t;

  iec_state_t state_reg;   // Registered state
  iec_state_t state_next;  // Next state
  logic [1:0] rst_sync_reg; // Reset release chain
  logic       rst_b_int;    // Synchronised reset

  // ========================================
  // Functions
  // Edge detection per two-bit selector
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    case (sel)
      `IEC_EDGE_RISE: edge_hit = rise;
      `IEC_EDGE_FALL: edge_hit = fall;
      `IEC_EDGE_BOTH: edge_hit = rise | fall;
      default:        edge_hit = 1'b0;
    endcase
  endfunction

  // Flag update: write of zero clears, event set wins
  function automatic logic [7:0] flag_upd(input logic [7:0] cur,
                                          input logic       wr,
                                          input logic [7:0] wd,
                                          input logic [7:0] clr,
                                          input logic [7:0] set);
    logic [7:0] kept;
    kept = wr ? (cur & wd) : cur;
    flag_upd = (kept & ~clr) | set;
  endfunction

  // ========================================
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b_int = rst_sync_reg[1];

  // ========================================
  // Next-state logic
  always_comb begin
    logic        acc;        // Bus access taken this cycle
    logic        wr;         // Register write taken
    logic [7:0]  wd;         // Write data byte
    logic [7:0]  idx;        // Register index
    logic [7:0]  set0;       // Pin 0-7 edge events
    logic [7:0]  set1;       // Upper pin and timer events
    logic [7:0]  clr1;       // Acknowledge clears
    logic [7:0]  ev_st;      // Status events
    logic [23:0] pend;       // Pending requests
    logic [23:0] en;         // Per-source enables
    logic [1:0]  lvl;        // Level of a source
    logic        found;      // Winner present
    logic [4:0]  win;        // Winning source
    logic [1:0]  win_lvl;    // Winning level
    logic        hold;       // Request held off
    state_next = state_reg;
    // Access commits at the edge that sees waitrequest low
    acc = (avs_req.read | avs_req.write) & state_reg.wait_n;
    wr = acc & avs_req.write & avs_req.byteenable[0];
    wd = avs_req.writedata[7:0];
    idx = avs_req.address;
    set0 = 8'h00;
    set1 = 8'h00;
    clr1 = 8'h00;
    ev_st = 8'h00;
    pend = 24'h00_0000;
    en = 24'h00_0000;
    lvl = 2'h0;
    found = 1'b0;
    win = 5'h00;
    win_lvl = 2'h0;
    hold = 1'b0;

    // Bus handshake: stall at idle, answer one cycle after request
    state_next.wait_n = (avs_req.read | avs_req.write) &
                        ~state_reg.wait_n;

    // Edge events on pins 0 to 7 and upper pins, timer events
    for (int i = 0; i < 4; i++) begin
      set0[i] = edge_hit(state_reg.pol_low[2*i +: 2], // R7
                         state_reg.pin_low_prev[i],
                         evt.pins_low[i]);
      set0[i+4] = edge_hit(state_reg.pol_high[2*i +: 2], // R6
                           state_reg.pin_low_prev[i+4],
                           evt.pins_low[i+4]);
      set1[i] = edge_hit(state_reg.pol_upper[2*i +: 2], // R8
                         state_reg.pin_up_prev[i],
                         evt.pins_upper[i]);
    end
    set1[`IEC_BIT_T0_OVF] = evt.t0_overflow;
    set1[`IEC_BIT_T0_MATCH] = evt.t0_match; // R10
    set1[`IEC_BIT_T3_EVENT] = evt.t3_event; // R11
    state_next.pin_low_prev = evt.pins_low;
    state_next.pin_up_prev = evt.pins_upper;

    // Acknowledge clears the matching flag of the upper register
    if (int_ack) begin
      case (ack_src)
        5'h00:   clr1[1] = 1'b1;                  // R9
        5'h01:   clr1[2] = 1'b1;                  // R9
        5'h06:   clr1[0] = 1'b1;                  // R9
        5'h0b:   clr1[3] = 1'b1;                  // R9
        5'h0c:   clr1[`IEC_BIT_T0_OVF] = 1'b1;
        5'h0d:   clr1[`IEC_BIT_T0_MATCH] = 1'b1;  // R10
        5'h10:   clr1[`IEC_BIT_T3_EVENT] = 1'b1;  // R11
        default: clr1 = 8'h00;
      endcase
    end

    // Flags: pin 0-7 flags ignore acknowledge
    state_next.flags0 = flag_upd(state_reg.flags0, // R5
                                 wr && idx == `IEC_IDX_FLAGS0,
                                 wd, 8'h00, set0);
    state_next.flags1 = flag_upd(state_reg.flags1, // R9
                                 wr && idx == `IEC_IDX_FLAGS1,
                                 wd, clr1, set1) & `IEC_IMPL_FLAGS1;

    // Status events: pins, upper pins, timers, acknowledge
    ev_st = {4'h0, int_ack, |set1[7:5], |set1[3:0], |set0};
    if (wr && idx == `IEC_IDX_STATUS) begin
      state_next.status = (state_reg.status & ~wd) | ev_st;
    end else begin
      state_next.status = state_reg.status | ev_st;
    end
    state_next.status = state_next.status & `IEC_IMPL_STATUS;

    // Plain control register writes
    if (wr) begin
      case (idx)
        `IEC_IDX_IE0:       state_next.ie0 = wd & `IEC_IMPL_IE0; // R1
        `IEC_IDX_IE1:       state_next.ie1 = wd & `IEC_IMPL_IE1; // R2
        `IEC_IDX_IE2:       state_next.ie2 = wd & `IEC_IMPL_IE2; // R3
        `IEC_IDX_IE3:       state_next.ie3 = wd & `IEC_IMPL_IE3; // R4
        `IEC_IDX_PRIO_LOW:  state_next.prio_low = wd & `IEC_IMPL_PRIO;
        `IEC_IDX_PRIO_HIGH: state_next.prio_high = wd & `IEC_IMPL_PRIO;
        `IEC_IDX_POL_LOW:   state_next.pol_low = wd;   // R7
        `IEC_IDX_POL_HIGH:  state_next.pol_high = wd;  // R6
        `IEC_IDX_POL_UPPER: state_next.pol_upper = wd; // R8
        `IEC_IDX_MASK:      state_next.mask = wd & `IEC_IMPL_STATUS;
        default:            state_next.mask = state_next.mask;
      endcase
      // Writes to enable or priority hold the request off
      hold = (idx >= `IEC_IDX_IE0 && idx <= `IEC_IDX_IE3) ||
             idx == `IEC_IDX_PRIO_LOW || idx == `IEC_IDX_PRIO_HIGH;
    end

    // Read data, loaded for the answer cycle; unmapped reads as zero
    state_next.rdata = `IEC_RST_WORD;
    if (avs_req.read && !state_reg.wait_n) begin
      case (idx)
        `IEC_IDX_IE0:       state_next.rdata[7:0] = state_reg.ie0;
        `IEC_IDX_IE1:       state_next.rdata[7:0] = state_reg.ie1;
        `IEC_IDX_IE2:       state_next.rdata[7:0] = state_reg.ie2;
        `IEC_IDX_IE3:       state_next.rdata[7:0] = state_reg.ie3;
        `IEC_IDX_PRIO_LOW:  state_next.rdata[7:0] = state_reg.prio_low;
        `IEC_IDX_PRIO_HIGH: state_next.rdata[7:0] = state_reg.prio_high;
        `IEC_IDX_POL_LOW:   state_next.rdata[7:0] = state_reg.pol_low;
        `IEC_IDX_POL_HIGH:  state_next.rdata[7:0] = state_reg.pol_high;
        `IEC_IDX_POL_UPPER: state_next.rdata[7:0] = state_reg.pol_upper;
        `IEC_IDX_FLAGS0:    state_next.rdata[7:0] = state_reg.flags0;
        `IEC_IDX_FLAGS1:    state_next.rdata[7:0] = state_reg.flags1;
        `IEC_IDX_STATUS:    state_next.rdata[7:0] = state_reg.status;
        `IEC_IDX_MASK:      state_next.rdata[7:0] = state_reg.mask;
        default:            state_next.rdata = `IEC_RST_WORD;
      endcase
    end

    // Pending request per source number
    pend = periph_req;
    pend[0] = state_reg.flags1[1];
    pend[1] = state_reg.flags1[2];
    pend[5] = |state_reg.flags0;
    pend[6] = state_reg.flags1[0];
    pend[11] = state_reg.flags1[3];
    pend[12] = state_reg.flags1[`IEC_BIT_T0_OVF];
    pend[13] = state_reg.flags1[`IEC_BIT_T0_MATCH];
    pend[16] = state_reg.flags1[`IEC_BIT_T3_EVENT];
    pend[7] = 1'b0;
    pend[23] = 1'b0;

    // Enables packed six per register, gated by global enable
    en = {state_reg.ie3[5:0], state_reg.ie2[5:0],       // R1 R2 R3 R4
          state_reg.ie1[5:0], state_reg.ie0[5:0]};
    if (!state_reg.ie0[`IEC_BIT_GLOBAL]) begin
      en = 24'h00_0000;                                 // R13
    end

    // Highest level wins; scan upward so lower number keeps ties
    for (int n = 0; n < `IEC_SRC_COUNT; n++) begin
      lvl = {state_reg.prio_high[n % `IEC_GROUP_COUNT], // R12 R14
             state_reg.prio_low[n % `IEC_GROUP_COUNT]};
      if (pend[n] && en[n] && (!found || lvl > win_lvl)) begin // R14
        found = 1'b1;
        win = 5'(n);
        win_lvl = lvl;
      end
    end
    state_next.cpu.req = found & ~hold & ~int_ack;      // R13
    state_next.cpu.src = win;
    state_next.cpu.level = win_lvl;

    // Summary interrupt from unmasked status bits
    state_next.irq = |(state_next.status & state_next.mask);
  end

  // ========================================
  // State register
  always_ff @(posedge clk or negedge rst_b_int) begin
    if (!rst_b_int) begin
      state_reg <= '0;
      state_reg.wait_n <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================
  // Outputs from flip-flops; waitrequest is the inverted wait_n
  assign avs_waitrequest = ~state_reg.wait_n;
  assign avs_readdata = state_reg.rdata;
  assign cpu_req = state_reg.cpu;
  assign irq = state_reg.irq;
endmodule

// ---- iec_ctrl_bench.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module iec_ctrl_bench;
  import iec_pkg::*;
  logic          clk, rst_b, ack_en, irq, int_ack, wt;
  iec_av_req_t   req;                        // Bus request
  iec_events_t   evt;                        // Pin and timer events
  iec_cpu_req_t  cpu;                        // Request to the core
  logic [23:0]   periph;                     // Other sources
  logic [31:0]   rdata;                      // Read data
  logic [4:0]    ack_src;                    // Acknowledged source
  int            error_cnt, n_checks, cyc;
  iec_ctrl DUT (.clk(clk), .rst_b(rst_b), .avs_req(req),
    .avs_waitrequest(wt), .avs_readdata(rdata), .evt(evt),
    .periph_req(periph), .int_ack(int_ack), .ack_src(ack_src),
    .cpu_req(cpu), .irq(irq));
  iec_cpu_model #(.ACK_DLY(2)) cpu_m (.clk(clk), .rst_b(rst_b),
    .ack_en(ack_en), .req(cpu), .int_ack(int_ack), .ack_src(ack_src));
  // ========================================
  // Shared tasks
  task automatic bus(input logic rd, input logic [7:0] a, d,
                     output logic [31:0] q);
    @(posedge clk);
    req <= '{rd, !rd, a, 4'h1, {24'h0, d}};
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);      // Hold until answered
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, e);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, q);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic pulse(input logic t0, t3);  // One-cycle timer events
    @(posedge clk);
    evt.t0_match <= t0;
    evt.t3_event <= t3;
    @(posedge clk);
    evt.t0_match <= 1'b0;
    evt.t3_event <= 1'b0;
  endtask
  // ========================================
  // Scenarios
  task automatic t_regs;                     // Reset values and masks
    logic [7:0] a [10] = '{8'ha4, 8'ha5, 8'ha7, 8'ha8, 8'ha9, 8'haa,
                           8'hab, 8'hb8, 8'hf8, 8'hd1};
    logic [7:0] m [10] = '{8'hff, 8'hff, 8'hff, 8'hbf, 8'h3d, 8'h3f,
                           8'h1f, 8'h3f, 8'h3f, 8'h0f};
    for (int i = 0; i < 10; i++) begin
      rchk("reset value", a[i], 8'h00);
      wr(a[i], 8'hff);
      rchk("written value", a[i], m[i]);
      wr(a[i], 8'h00);
    end
    wr(8'h00, 8'hff);
    rchk("unmapped", 8'h00, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pins;                     // Every edge code
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'ha4, {4{c}});
      wr(8'ha5, {4{c}});
      wr(8'ha7, {4{c}});
      @(posedge clk) evt.pins_low <= 8'hff;
      evt.pins_upper <= 4'hf;
      rchk("rise low", 8'hc0, {8{c[0]}});
      rchk("rise upper", 8'ha6, {4'h0, {4{c[0]}}});
      wr(8'hc0, 8'h00);
      wr(8'ha6, 8'h00);
      @(posedge clk) evt.pins_low <= 8'h00;
      evt.pins_upper <= 4'h0;
      rchk("fall low", 8'hc0, {8{c[1]}});
      rchk("fall upper", 8'ha6, {4'h0, {4{c[1]}}});
      wr(8'hc0, 8'h7f);
      rchk("one keeps", 8'hc0, {1'b0, {7{c[1]}}});
      wr(8'hc0, 8'h00);
      wr(8'ha6, 8'h00);
    end
    $display("test pins done");
  endtask
  task automatic t_timer;                    // Acknowledge and global off
    int n;
    ack_en <= 1'b1;
    wr(8'ha8, 8'h80);
    wr(8'haa, 8'h02);
    pulse(1'b1, 1'b0);
    n = 0;
    while (int_ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("ack source", {27'h0, ack_src}, 32'd13);
    rchk("flag after ack", 8'ha6, 8'h00);
    wr(8'ha8, 8'h00);
    pulse(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk("request off", {31'h0, cpu.req}, 32'h0);
    rchk("t3 flag", 8'ha6, 8'h20);
    wr(8'ha6, 8'h00);
    rchk("t3 cleared", 8'ha6, 8'h00);
    ack_en <= 1'b0;
    $display("test timer done");
  endtask
  task automatic t_prio;                     // Levels and ties
    logic [7:0] lo [4] = '{8'h00, 8'h10, 8'h02, 8'h00};
    logic [7:0] hi [4] = '{8'h10, 8'h00, 8'h02, 8'h00};
    logic [6:0] ex [4] = '{{5'd16, 2'd2}, {5'd16, 2'd1},
                           {5'd13, 2'd3}, {5'd13, 2'd0}};
    wr(8'ha8, 8'h80);
    wr(8'haa, 8'h12);
    pulse(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(8'hb8, lo[i]);
      wr(8'hf8, hi[i]);
      repeat (3) @(posedge clk);
      chk("winner", {25'h0, cpu.src, cpu.level}, {25'h0, ex[i]});
    end
    ack_en <= 1'b1;
    repeat (20) @(posedge clk);
    rchk("flags acked", 8'ha6, 8'h00);
    ack_en <= 1'b0;
    $display("test prio done");
  endtask
  task automatic t_irq;                      // Status, mask and line
    rchk("status", 8'hd0, 8'h0f);
    wr(8'hd1, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(8'hd1, 8'h04);
    repeat (2) @(posedge clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(8'hd0, 8'h04);
    repeat (2) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rchk("status left", 8'hd0, 8'h0b);
    $display("test irq done");
  endtask
  // ========================================
  // Verdict, clock, timeout and main sequence
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin                // Hang guard
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    {rst_b, ack_en, req, evt, periph, cyc, error_cnt, n_checks} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    t_regs;
    t_pins;
    t_timer;
    t_prio;
    t_irq;
    close_out;
  end
endmodule

// ---- iec_ctrl_checker.sv ----
// Port assertions for the interrupt controller
`timescale 1ns/1ps
module iec_ctrl_checker (
  input wire logic                 clk,             // Clock
  input wire logic                 rst_b,           // Reset, low
  input wire iec_pkg::iec_av_req_t avs_req,         // Bus request
  input wire logic                 avs_waitrequest, // Bus stall
  input wire logic [31:0]          avs_readdata,    // Read data
  input wire logic                 int_ack,         // Acknowledge
  input wire iec_pkg::iec_cpu_req_t cpu_req,        // CPU request
  input wire logic                 irq              // Summary line
);
  import iec_pkg::*;
  // ========================================
  // Shared clocking and bus sequences
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Read of one index completing at this edge
  sequence rd_at(a);
    avs_req.read && avs_req.address == a && !avs_waitrequest;
  endsequence
  // Write of one index completing at this edge
  sequence wr_at(a);
    avs_req.write && avs_req.byteenable[0] && avs_req.address == a
      && !avs_waitrequest;
  endsequence
  // ========================================
  // Assertions
  a_wait_single: assert property ((avs_req.read || avs_req.write)
    && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 0)
    else $error("read data outside answer");
  a_ie1_unimpl: assert property (rd_at(8'ha9) |->
    avs_readdata[7:6] == 2'h0 && !avs_readdata[1]) else $error("ie1 bits");
  a_ie2_unimpl: assert property (rd_at(8'haa) |->
    avs_readdata[7:6] == 2'h0) else $error("ie2 bits");
  a_ie3_unimpl: assert property (rd_at(8'hab) |->
    avs_readdata[7:5] == 3'h0) else $error("ie3 bits");
  a_flag_bit4: assert property (rd_at(8'ha6) |-> !avs_readdata[4])
    else $error("flags1 bit 4 set");
  a_ack_drops: assert property (int_ack |=> !cpu_req.req)
    else $error("request after acknowledge");
  a_global_off: assert property (wr_at(8'ha8) ##0 !avs_req.writedata[7]
    |-> ##2 !cpu_req.req [*2]) else $error("request with global off");
  a_src_range: assert property (cpu_req.req |-> cpu_req.src < 5'h18)
    else $error("source out of range");
  a_mask_irq: assert property (wr_at(8'hd1) ##0
    avs_req.writedata[7:0] == 8'h00 |=> ##1 !irq) else $error("irq masked");
endmodule
bind iec_ctrl iec_ctrl_checker chk_i (.clk(clk), .rst_b(rst_b),
  .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .int_ack(int_ack), .cpu_req(cpu_req),
  .irq(irq));

// ---- iec_params.svh ----
// Constants for the interrupt enable and priority block
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH
// ========================================
// Register indices (byte address = 4 x index)
`define IEC_IDX_POL_LOW   8'ha4
`define IEC_IDX_POL_HIGH  8'ha5
`define IEC_IDX_FLAGS1    8'ha6
`define IEC_IDX_POL_UPPER 8'ha7
`define IEC_IDX_IE0       8'ha8
`define IEC_IDX_IE1       8'ha9
`define IEC_IDX_IE2       8'haa
`define IEC_IDX_IE3       8'hab
`define IEC_IDX_PRIO_LOW  8'hb8
`define IEC_IDX_FLAGS0    8'hc0
`define IEC_IDX_STATUS    8'hd0
`define IEC_IDX_MASK      8'hd1
`define IEC_IDX_PRIO_HIGH 8'hf8
// ========================================
// Reset values and implemented-bit masks
`define IEC_RST_BYTE      8'h00
`define IEC_RST_WORD      32'h0000_0000
`define IEC_IMPL_IE0      8'hbf
`define IEC_IMPL_IE1      8'h3d
`define IEC_IMPL_IE2      8'h3f
`define IEC_IMPL_IE3      8'h1f
`define IEC_IMPL_PRIO     8'h3f
`define IEC_IMPL_FLAGS1   8'hef
`define IEC_IMPL_STATUS   8'h0f
// ========================================
// Field positions
`define IEC_BIT_GLOBAL    7
`define IEC_BIT_T0_OVF    7
`define IEC_BIT_T0_MATCH  6
`define IEC_BIT_T3_EVENT  5
`define IEC_SRC_COUNT     24
`define IEC_GROUP_COUNT   6
// ========================================
// Edge selector codes
`define IEC_EDGE_NONE     2'h0
`define IEC_EDGE_RISE     2'h1
`define IEC_EDGE_FALL     2'h2
`define IEC_EDGE_BOTH     2'h3
`endif

// ---- iec_pkg.sv ----
// Types shared by the interrupt enable and priority block
package iec_pkg;
  // Avalon-MM request from the bus master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } iec_av_req_t;
  // Pin and timer event inputs
  typedef struct packed {
    logic [7:0] pins_low;
    logic [3:0] pins_upper;
    logic       t0_overflow;
    logic       t0_match;
    logic       t3_event;
  } iec_events_t;
  // Request presented to the CPU core
  typedef struct packed {
    logic       req;
    logic [4:0] src;
    logic [1:0] level;
  } iec_cpu_req_t;
endpackage
